// [design/ftm_channel.sv]
// Purpose: one fan speed monitor channel with its three registers
// Assumes: register strobes come from the serial slave, one cycle each
// Notes:   compare uses reach-or-pass, the stricter reading is not taken
`timescale 1ns/1ns
`default_nettype none
`include "ftm_regs.svh"
module ftm_channel #(
    parameter int P_REF_CYCLES = `FTM_REF_CYCLES
) (
    input  wire logic       i_clock,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_write,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_irq_clear,
    input  wire logic       i_tach_input_pin,
    input  wire logic       i_bypass_select,
    output logic [7:0]      o_reg_rdata,
    output logic            o_irq_n,
    output logic [7:0]      o_interrupt_source_reg,
    output logic            o_tach_input_mode
);
    ftm_tach_if tif ();

    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] thresh_r, thresh_nxt;
    logic [7:0] count_r, count_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] src_r, src_nxt;
    logic       irq_n_r, irq_n_nxt;
    logic       mode_r, mode_nxt;
    ftm_pkg::ftm_irq_state_t st_r, st_nxt;
    logic       mon_en, irq_en, cond, raise, clr_ok;

    // -------------------------------------------------------------
    // counter
    // -------------------------------------------------------------
    ftm_tach_counter #(
        .P_REF_CYCLES (P_REF_CYCLES)
    ) u_cnt (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .tif     (tif)
    );

    assign mon_en      = ctrl_r[`FTM_CTRL_EN_BIT];
    assign irq_en      = ctrl_r[`FTM_CTRL_IRQ_BIT];
    assign tif.enable  = mon_en;
    assign tif.div_sel = ctrl_r[`FTM_CTRL_DIV_HI:`FTM_CTRL_DIV_LO];
    assign tif.tach    = i_tach_input_pin;
    assign tif.restart = clr_ok;

    // -------------------------------------------------------------
    // registers and interrupt
    // -------------------------------------------------------------
    always_comb begin
        ctrl_nxt   = ctrl_r;
        thresh_nxt = thresh_r;
        if (i_reg_write && i_reg_addr == `FTM_ADDR_CTRL) begin
            // bits 5:2 are reserved and stay zero
            ctrl_nxt = i_reg_wdata & `FTM_CTRL_WMASK;
        end
        if (i_reg_write && i_reg_addr == `FTM_ADDR_THRESH) begin
            thresh_nxt = i_reg_wdata;
        end
        // live compare so a stall is caught before a turn completes
        cond   = mon_en && irq_en
                 && (tif.run_count >= thresh_r);
        raise  = cond && st_r == ftm_pkg::FTM_IRQ_IDLE;
        clr_ok = i_irq_clear && st_r == ftm_pkg::FTM_IRQ_PEND && !cond;
        st_nxt = st_r;
        src_nxt = src_r;
        // a new condition beats a clear in the same cycle
        if (cond) begin
            st_nxt = ftm_pkg::FTM_IRQ_PEND;
        end else if (clr_ok || !irq_en || !mon_en) begin
            st_nxt = ftm_pkg::FTM_IRQ_IDLE;
        end
        if (raise) begin
            src_nxt = `FTM_ADDR_CTRL;
        end else if (st_nxt == ftm_pkg::FTM_IRQ_IDLE) begin
            src_nxt = 8'h00;
        end
        irq_n_nxt = (st_nxt != ftm_pkg::FTM_IRQ_PEND);
        count_nxt = count_r;
        if (!mon_en || clr_ok) begin
            count_nxt = `FTM_COUNT_RESET;
        end else if (st_r == ftm_pkg::FTM_IRQ_PEND) begin
            count_nxt = count_r;
        end else if (tif.rev_done) begin
            count_nxt = tif.run_count;
        end else if (tif.run_count == `FTM_COUNT_MAX) begin
            count_nxt = `FTM_COUNT_MAX;
        end
        mode_nxt = mon_en && !i_bypass_select;
        case (i_reg_addr)
            `FTM_ADDR_CTRL:   rdata_nxt = ctrl_r;
            `FTM_ADDR_THRESH: rdata_nxt = thresh_r;
            `FTM_ADDR_COUNT:  rdata_nxt = count_r;
            default:          rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ctrl_r   <= `FTM_CTRL_RESET;
            thresh_r <= `FTM_THRESH_RESET;
            count_r  <= `FTM_COUNT_RESET;
            rdata_r  <= 8'h00;
            src_r    <= 8'h00;
            irq_n_r  <= 1'b1;
            mode_r   <= 1'b0;
            st_r     <= ftm_pkg::FTM_IRQ_IDLE;
        end else begin
            ctrl_r   <= ctrl_nxt;
            thresh_r <= thresh_nxt;
            count_r  <= count_nxt;
            rdata_r  <= rdata_nxt;
            src_r    <= src_nxt;
            irq_n_r  <= irq_n_nxt;
            mode_r   <= mode_nxt;
            st_r     <= st_nxt;
        end
    end

    assign o_reg_rdata            = rdata_r;
    assign o_irq_n                = irq_n_r;
    assign o_interrupt_source_reg = src_r;
    assign o_tach_input_mode      = mode_r;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    sequence s_idle_reach;
        st_r == ftm_pkg::FTM_IRQ_IDLE && mon_en && irq_en
        && tif.run_count >= thresh_r;
    endsequence

    sequence s_raised;
        !o_irq_n && o_interrupt_source_reg == `FTM_ADDR_CTRL;
    endsequence

    sequence s_cleared;
        count_r == 8'h00 && o_irq_n && o_interrupt_source_reg == 8'h00;
    endsequence

    irq_on_reach_a:
    assert property (s_idle_reach |=> s_raised)
        else $error("no interrupt when counter reached threshold");

    irq_line_state_a:
    assert property (o_irq_n != (o_interrupt_source_reg == `FTM_ADDR_CTRL))
        else $error("interrupt line disagrees with source register");

    no_irq_disabled_a:
    assert property (!irq_en |=> o_irq_n)
        else $error("interrupt while irq enable clear");

    thresh_write_a:
    assert property (i_reg_write && i_reg_addr == `FTM_ADDR_THRESH
                     |=> thresh_r == $past(i_reg_wdata))
        else $error("threshold write lost");

    count_freeze_a:
    assert property (st_r == ftm_pkg::FTM_IRQ_PEND && !i_irq_clear
                     && mon_en |=> $stable(count_r))
        else $error("count moved while interrupt pending");

    count_clear_a:
    assert property (clr_ok |=> s_cleared)
        else $error("count not cleared with the interrupt");

    pin_mode_a:
    assert property (mon_en && !i_bypass_select |=> o_tach_input_mode)
        else $error("pin not turned to tach input");

    turn_capture_a:
    assert property (tif.rev_done && st_r == ftm_pkg::FTM_IRQ_IDLE
                     && mon_en && !clr_ok
                     |=> count_r == $past(tif.run_count))
        else $error("turn count not captured");

    // set wins: a clear against a live condition is dropped
    clear_refused_a:
    assert property (cond && i_irq_clear |=> !o_irq_n)
        else $error("clear won over a standing condition");

    pend_holds_a:
    assert property (st_r == ftm_pkg::FTM_IRQ_PEND && mon_en && irq_en
                     && !i_irq_clear |=> !o_irq_n)
        else $error("interrupt dropped without a clear");

    count_stall_a:
    assert property (mon_en && st_r == ftm_pkg::FTM_IRQ_IDLE
                     && tif.run_count == `FTM_COUNT_MAX
                     |=> count_r == `FTM_COUNT_MAX)
        else $error("stalled fan not reported as all ones");

    count_off_a:
    assert property (!mon_en |=> count_r == `FTM_COUNT_RESET)
        else $error("count kept while monitoring disabled");

    ctrl_write_a:
    assert property (i_reg_write && i_reg_addr == `FTM_ADDR_CTRL
                     |=> ctrl_r == ($past(i_reg_wdata) & `FTM_CTRL_WMASK))
        else $error("control write not stored");

    count_read_a:
    assert property (i_reg_addr == `FTM_ADDR_COUNT
                     |=> o_reg_rdata == $past(count_r))
        else $error("count read does not match register");

    thresh_read_a:
    assert property (i_reg_addr == `FTM_ADDR_THRESH
                     |=> o_reg_rdata == $past(thresh_r))
        else $error("threshold read does not match register");

    pin_release_a:
    assert property (!mon_en || i_bypass_select |=> !o_tach_input_mode)
        else $error("pin held as tach input while released");

endmodule
`default_nettype wire

// [design/ftm_pkg.sv]
// Purpose: shared types of the fan tach monitor
// Assumes: nothing beyond the register header
// Notes:   divisor decode is used by the counter only, no check calls it
package ftm_pkg;

    typedef enum logic [1:0] {
        FTM_DIV_1,
        FTM_DIV_2,
        FTM_DIV_4,
        FTM_DIV_8
    } ftm_div_t;

    typedef enum logic {
        FTM_IRQ_IDLE,
        FTM_IRQ_PEND
    } ftm_irq_state_t;

    function automatic logic [3:0] ftm_div_ticks(input logic [1:0] sel);
        case (sel)
            FTM_DIV_1: ftm_div_ticks = 4'h1;
            FTM_DIV_2: ftm_div_ticks = 4'h2;
            FTM_DIV_4: ftm_div_ticks = 4'h4;
            default:   ftm_div_ticks = 4'h8;
        endcase
    endfunction

endpackage

// [design/ftm_regs.svh]
// Purpose: register map, field positions and timing counts, fan tach monitor
// Assumes: 100 MHz core clock, registers at their printed addresses
// Notes:   one channel only; shared source register lives outside
//
// Behaviour
// - with enable bit 7 and irq enable set, interrupt when counter reaches or passes threshold
// - interrupt drives active-low line and loads control address as source
// - irq enable clear means the channel never raises an interrupt condition
// - divisor bits 1:0 select divide by 1, 2, 4 or 8
// - count per revolution equals 1,200,000 over RPM times divisor
// - 8-bit read/write threshold, reset zero, compared with counter continuously
// - tach pulses gate 20 kHz reference into counter, two pulses a turn
// - enable bit 7 makes the pin a tach input except under bypass
// - count updates each revolution, freezes on interrupt, clears on clear
// - count 00h means no full turn yet, FFh means stalled or absent
`ifndef FTM_REGS_SVH
`define FTM_REGS_SVH

// -------------------------------------------------------------
// register addresses
// -------------------------------------------------------------
`define FTM_ADDR_CTRL      8'h4C
`define FTM_ADDR_THRESH    8'h4D
`define FTM_ADDR_COUNT     8'h4E

// -------------------------------------------------------------
// control fields and reset values
// -------------------------------------------------------------
`define FTM_CTRL_EN_BIT    7
`define FTM_CTRL_IRQ_BIT   6
`define FTM_CTRL_DIV_HI    1
`define FTM_CTRL_DIV_LO    0
`define FTM_CTRL_WMASK     8'hC3
`define FTM_CTRL_RESET     8'h00
`define FTM_THRESH_RESET   8'h00
`define FTM_COUNT_RESET    8'h00
`define FTM_COUNT_MAX      8'hFF

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define FTM_CLK_HZ         100000000
`define FTM_REF_HZ         20000
`define FTM_REF_CYCLES     (`FTM_CLK_HZ / `FTM_REF_HZ)

`endif

// [design/ftm_tach_counter.sv]
// Purpose: reference tick, divisor prescale and per-turn tach counter
// Assumes: tach input already clean and synchronous
// Notes:   first rising edge starts timing, every second edge ends a turn
`timescale 1ns/1ns
`default_nettype none
`include "ftm_regs.svh"
module ftm_tach_counter #(
    parameter int P_REF_CYCLES = `FTM_REF_CYCLES
) (
    input  wire logic   i_clock,
    input  wire logic   i_reset,
    ftm_tach_if.cnt     tif
);
    logic [12:0] ref_cnt_r, ref_cnt_nxt;
    logic [3:0]  pre_cnt_r, pre_cnt_nxt;
    logic [7:0]  run_r, run_nxt;
    logic        prev_r, prev_nxt;
    logic        started_r, started_nxt;
    logic        half_r, half_nxt;
    logic        ref_tick, cnt_inc, rise;

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        ref_cnt_nxt = ref_cnt_r + 13'h1;
        pre_cnt_nxt = pre_cnt_r;
        run_nxt     = run_r;
        started_nxt = started_r;
        half_nxt    = half_r;
        prev_nxt    = tif.tach;
        rise        = tif.tach & ~prev_r;
        ref_tick    = (ref_cnt_r == 13'(P_REF_CYCLES - 1));
        cnt_inc     = 1'b0;
        tif.rev_done = 1'b0;
        if (ref_tick) begin
            ref_cnt_nxt = 13'h0;
            if (pre_cnt_r == 4'(ftm_pkg::ftm_div_ticks(tif.div_sel)
                                - 4'h1)) begin
                pre_cnt_nxt = 4'h0;
                cnt_inc     = started_r;
            end else begin
                pre_cnt_nxt = pre_cnt_r + 4'h1;
            end
        end
        // saturate so a stalled fan keeps reporting the maximum
        if (cnt_inc && run_r != `FTM_COUNT_MAX) begin
            run_nxt = run_r + 8'h1;
        end
        if (rise) begin
            if (!started_r) begin
                started_nxt = 1'b1;
                half_nxt    = 1'b0;
                run_nxt     = 8'h00;
            end else if (!half_r) begin
                half_nxt = 1'b1;
            end else begin
                tif.rev_done = 1'b1;
                half_nxt     = 1'b0;
                run_nxt      = 8'h00;
            end
        end
        if (!tif.enable || tif.restart) begin
            ref_cnt_nxt = 13'h0;
            pre_cnt_nxt = 4'h0;
            run_nxt     = 8'h00;
            started_nxt = 1'b0;
            half_nxt    = 1'b0;
        end
    end

    assign tif.run_count = run_r;

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            ref_cnt_r <= 13'h0;
            pre_cnt_r <= 4'h0;
            run_r     <= 8'h00;
            prev_r    <= 1'b0;
            started_r <= 1'b0;
            half_r    <= 1'b0;
        end else begin
            ref_cnt_r <= ref_cnt_nxt;
            pre_cnt_r <= pre_cnt_nxt;
            run_r     <= run_nxt;
            prev_r    <= prev_nxt;
            started_r <= started_nxt;
            half_r    <= half_nxt;
        end
    end

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    counter_saturates_a:
    assert property (run_r == `FTM_COUNT_MAX && tif.enable && !tif.restart
                     && !rise |=> run_r == `FTM_COUNT_MAX)
        else $error("tach counter wrapped past all ones");

    turn_restart_a:
    assert property (tif.rev_done && tif.enable && !tif.restart
                     |=> run_r <= 8'h01)
        else $error("counter not restarted after a turn");

    disabled_idle_a:
    assert property (!tif.enable |=> run_r == 8'h00 && !started_r)
        else $error("counter active while monitoring disabled");

endmodule
`default_nettype wire

// [design/ftm_tach_if.sv]
// Purpose: link between channel registers and the tach counter
// Assumes: single clock domain
// Notes:   rev_done is a one-cycle pulse with run_count holding the turn
`timescale 1ns/1ns
`default_nettype none
interface ftm_tach_if;
    logic       enable;
    logic       restart;
    logic [1:0] div_sel;
    logic       tach;
    logic       rev_done;
    logic [7:0] run_count;

    modport ctrl (output enable, output restart, output div_sel,
                  output tach, input rev_done, input run_count);
    modport cnt  (input enable, input restart, input div_sel,
                  input tach, output rev_done, output run_count);
endinterface
`default_nettype wire

// [verification/fan_tach_speed_monitor_tb.sv]
// Purpose: register-level tests of one fan speed monitor channel
// Assumes: reference tick shortened to 4 clocks, so a turn of 600*div
// Notes:   count compares allow one tick of phase slack at turn edges
`timescale 1ns/1ns
`default_nettype none
`include "ftm_regs.svh"
module fan_tach_speed_monitor_tb;
    localparam logic [7:0] a_ctl = `FTM_ADDR_CTRL;
    localparam logic [7:0] a_thr = `FTM_ADDR_THRESH;
    localparam logic [7:0] a_cnt = `FTM_ADDR_COUNT;

    logic        clk;
    logic        rst;
    logic        wr_en;
    logic        irq_clr;
    logic        bypass;
    logic        fan_run;
    logic        tach;
    logic        irq_n;
    logic        tach_mode;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  src;
    logic [7:0]  v;
    logic [15:0] half;
    int          error_cnt;
    int          checks_done;

    ftm_channel #(.P_REF_CYCLES(4)) dut (
        .i_clock(clk), .i_reset(rst), .i_reg_addr(addr),
        .i_reg_write(wr_en), .i_reg_wdata(wdata), .i_irq_clear(irq_clr),
        .i_tach_input_pin(tach), .i_bypass_select(bypass),
        .o_reg_rdata(rdata), .o_irq_n(irq_n),
        .o_interrupt_source_reg(src), .o_tach_input_mode(tach_mode)
    );

    ftm_fan_model fan (
        .i_clock(clk), .i_run(fan_run), .i_half(half), .o_tach(tach)
    );

    always #5 clk = ~clk;

    // -------------------------------------------------------------
    // access and compare tasks
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk1(input string name, input logic seen, input logic exp);
        check(name, {7'h00, seen}, {7'h00, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // read data lags the address by one edge; one spare edge for margin
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1 d = rdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp,
                       input string name);
        logic [7:0] d;
        rd(a, d);
        check(name, d, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_irq(input int n);
        int k;
        k = 0;
        while (irq_n !== 1'b0 && k < n) begin
            cyc(1);
            k++;
        end
        #1;
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        finish_test();
    end

    // -------------------------------------------------------------
    // test sequence
    // -------------------------------------------------------------
    initial begin
        clk = 1'b0; rst = 1'b1; wr_en = 1'b0; irq_clr = 1'b0;
        bypass = 1'b0; fan_run = 1'b1; half = 16'h0096;
        addr = 8'h00; wdata = 8'h00; error_cnt = 0; checks_done = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(a_ctl, 8'h00, "ctrl");
        rdc(a_thr, 8'h00, "thresh");
        rdc(a_cnt, 8'h00, "count");
        chk1("irq_n", irq_n, 1'b1);
        chk1("tach_mode", tach_mode, 1'b0);
        wr(a_thr, 8'hD6);
        rdc(a_thr, 8'hD6, "thresh");
        wr(a_ctl, 8'h3C);
        rdc(a_ctl, 8'h00, "ctrl");
        wr(a_cnt, 8'h55);
        rdc(a_cnt, 8'h00, "count");
        wr(8'h10, 8'hAA);
        rdc(8'h10, 8'h00, "unmapped");
        // every divisor at its nominal speed gives 150 counts a turn
        for (int d = 0; d < 4; d++) begin
            wr(a_ctl, 8'h00);
            half <= 16'h0096 << d;
            wr(a_thr, 8'hFA);
            wr(a_ctl, 8'h80 | 8'(d));
            rdc(a_cnt, 8'h00, "count");
            rdc(a_ctl, 8'h80 | 8'(d), "ctrl");
            chk1("tach_mode", tach_mode, 1'b1);
            cyc(1800 << d);
            rd(a_cnt, v);
            chk1("count150", v >= 8'h95 && v <= 8'h97, 1'b1);
            chk1("irq_n", irq_n, 1'b1);
        end
        // half speed saturates past the 60 percent threshold
        wr(a_ctl, 8'h00);
        half <= 16'h012C;
        wr(a_thr, 8'hFA);
        wr(a_ctl, 8'hC0);
        wait_irq(3000);
        chk1("irq_n", irq_n, 1'b0);
        check("source", src, 8'h4C);
        rd(a_cnt, v);
        cyc(1500);
        rdc(a_cnt, v, "frozen");
        @(posedge clk) half <= 16'h0096;
        cyc(1500);
        @(posedge clk) irq_clr <= 1'b1;
        @(posedge clk) irq_clr <= 1'b0;
        cyc(2);
        chk1("irq_n", irq_n, 1'b1);
        check("source", src, 8'h00);
        rdc(a_cnt, 8'h00, "count");
        // stalled fan mid-turn: count climbs to all ones and stays
        wr(a_ctl, 8'h80);
        cyc(400);
        @(posedge clk) fan_run <= 1'b0;
        cyc(3000);
        rdc(a_cnt, 8'hFF, "count");
        cyc(1100);
        rdc(a_cnt, 8'hFF, "count");
        // zero threshold: reach-or-pass fires at once, only when enabled
        @(posedge clk) fan_run <= 1'b1;
        wr(a_ctl, 8'h00);
        wr(a_thr, 8'h00);
        wr(a_ctl, 8'h80);
        cyc(50);
        chk1("irq_n", irq_n, 1'b1);
        wr(a_ctl, 8'hC3);
        cyc(3);
        chk1("irq_n", irq_n, 1'b0);
        check("source", src, 8'h4C);
        rdc(a_ctl, 8'hC3, "ctrl");
        wr(a_ctl, 8'h83);
        cyc(3);
        chk1("irq_n", irq_n, 1'b1);
        chk1("tach_mode", tach_mode, 1'b1);
        @(posedge clk) bypass <= 1'b1;
        cyc(3);
        chk1("tach_mode", tach_mode, 1'b0);
        @(posedge clk) bypass <= 1'b0;
        wr(a_ctl, 8'h03);
        cyc(3);
        chk1("tach_mode", tach_mode, 1'b0);
        // clear against a live condition is dropped, then a mid-run reset
        wr(a_ctl, 8'hC0);
        cyc(3);
        @(posedge clk) irq_clr <= 1'b1;
        @(posedge clk) irq_clr <= 1'b0;
        cyc(2);
        chk1("irq_n", irq_n, 1'b0);
        check("source", src, 8'h4C);
        wr(a_thr, 8'hD6);
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        cyc(1);
        chk1("irq_n", irq_n, 1'b1);
        check("source", src, 8'h00);
        chk1("tach_mode", tach_mode, 1'b0);
        rdc(a_thr, 8'h00, "thresh");
        rdc(a_ctl, 8'h00, "ctrl");
        rdc(a_cnt, 8'h00, "count");
        finish_test();
    end
endmodule
`default_nettype wire

// [verification/ftm_fan_model.sv]
// Purpose: fan tachometer output feeding the monitor pin
// Assumes: half period given in core clocks, at least 2
// Notes:   a stopped fan rests its output low, no free-running edges
`timescale 1ns/1ns
`default_nettype none
module ftm_fan_model (
    input  wire logic        i_clock,
    input  wire logic        i_run,
    input  wire logic [15:0] i_half,
    output logic             o_tach
);
    // -------------------------------------------------------------
    // tach pulse train
    // -------------------------------------------------------------
    logic [15:0] cnt_r;

    initial o_tach = 1'b0;
    initial cnt_r = 16'h0000;

    always @(posedge i_clock) begin
        if (!i_run) begin
            cnt_r  <= 16'h0000;
            o_tach <= 1'b0;
        end else if (cnt_r + 16'h0001 >= i_half) begin
            cnt_r  <= 16'h0000;
            // two pulses a turn: one turn is four half periods
            o_tach <= ~o_tach;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule
`default_nettype wire
